// >>> logic/emulation_memory_mapper.sv
// Our own choices: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/100ps
// Emulation memory mapper: AHB-Lite register slave plus per-cycle memory steering.
module emulation_memory_mapper (
	input  wire logic        hclk,               // Bus and processor clock.
	input  wire logic        hresetn,            // Asynchronous reset, active low.
	input  wire logic        hsel,               // Slave select.
	input  wire logic [31:0] haddr,              // Byte address.
	input  wire logic [1:0]  htrans,             // Transfer type.
	input  wire logic        hwrite,             // Write when high.
	input  wire logic [2:0]  hsize,              // Transfer size, word only.
	input  wire logic [31:0] hwdata,             // Write data.
	input  wire logic        hready,             // Bus ready.
	output logic      [31:0] hrdata,             // Read data.
	output logic             hreadyout,          // Slave ready.
	output logic             hresp,              // Always OKAY.
	output logic             irq,                // Level interrupt.
	input  wire logic        cyc_start,          // Processor address valid, one cycle.
	input  wire logic [31:0] cyc_addr,           // Processor cycle address.
	input  wire logic        cyc_write,          // Processor cycle is a write.
	input  wire logic        xfer_ack_in,        // Target transfer acknowledge.
	input  wire logic        xfer_error_ack_in,  // Target error acknowledge.
	output logic             emul_sel,           // Cycle goes to emulation memory.
	output logic      [2:0]  emul_block,         // Physical block for the cycle.
	output logic             emul_dual_port,     // Block is host reachable directly.
	output logic             target_sel,         // Cycle goes to target memory.
	output logic             cache_inhibit,      // Transfer cache inhibit to processor.
	output logic             cyc_ack,            // Internal termination pulse.
	output logic             cyc_err_ack,        // Error termination pulse.
	output logic             monitor_break,      // Break request pulse.
	output logic             guarded_hit         // Guarded access pulse.
);
	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_INTERN = 4'b0010,
		ST_LOCKED = 4'b0100,
		ST_TARGET = 4'b1000
	} cyc_state_e;

	cyc_state_e  state_ff;
	cyc_state_e  nxt_state;
	logic [23:0] start_ff [7];
	logic [23:0] end_ff [7];
	logic [5:0]  attr_ff [7];
	logic [9:0]  ctrl_ff;
	logic [31:0] mon_base_ff;
	logic [2:0]  status_ff;
	logic [2:0]  mask_ff;
	logic        wr_pend_ff;
	logic        rd_pend_ff;
	logic [7:0]  addr_ff;
	logic [31:0] hrdata_ff;
	logic        hreadyout_ff;
	logic        irq_ff;
	logic        emul_sel_ff;
	logic [2:0]  emul_block_ff;
	logic        emul_dual_port_ff;
	logic        target_sel_ff;
	logic        cache_inhibit_ff;
	logic        cyc_ack_ff;
	logic        cyc_err_ack_ff;
	logic        monitor_break_ff;
	logic        guarded_hit_ff;
	logic        pend_break_ff;
	logic [2:0]  term_block [7];
	logic [24:0] term_pages [7];
	logic [6:0]  term_fail;
	logic [6:0]  term_emul;
	logic [6:0]  term_dp_req;
	logic [6:0]  term_hit;
	logic [31:0] rdata;

	// Bus phase decode.
	wire         addr_phase = hsel & htrans[1] & hready;
	wire         wr_ctrl    = wr_pend_ff && addr_ff == mapper_pkg::OFS_CTRL;
	wire         wr_base    = wr_pend_ff && addr_ff == mapper_pkg::OFS_MON_BASE;
	wire         wr_cmd     = wr_pend_ff && addr_ff == mapper_pkg::OFS_CMD;
	wire         wr_status  = wr_pend_ff && addr_ff == mapper_pkg::OFS_STATUS;
	wire         wr_mask    = wr_pend_ff && addr_ff == mapper_pkg::OFS_MASK;
	wire         wr_term    = wr_pend_ff && addr_ff[7] && addr_ff[6:4] != 3'h7;
	wire [2:0]   term_idx   = addr_ff[6:4];
	wire         mon_change = wr_ctrl && hwdata[mapper_pkg::CTRL_MON_BG] != ctrl_ff[mapper_pkg::CTRL_MON_BG];
	wire         base_change = wr_base && hwdata != mon_base_ff;
	wire         map_clear  = (wr_cmd && hwdata[mapper_pkg::CMD_MAP_RESET]) || mon_change || base_change;

	// Control fields.
	wire         mon_bg     = ctrl_ff[mapper_pkg::CTRL_MON_BG];
	wire         rom_brk_en = ctrl_ff[mapper_pkg::CTRL_ROM_BRK];
	wire [2:0]   def_type   = ctrl_ff[mapper_pkg::CTRL_DEF_LSB +: 3];

	// Per-term compare: every term is checked at once against the live address.
	genvar gi;
	generate
		for (gi = 0; gi < mapper_pkg::NUM_TERMS; gi++) begin : g_term
			wire [2:0] ttype = attr_ff[gi][mapper_pkg::ATTR_TYPE_LSB +: 3];
			assign term_emul[gi]   = ttype == mapper_pkg::TYPE_ERAM || ttype == mapper_pkg::TYPE_EROM;
			assign term_dp_req[gi] = attr_ff[gi][mapper_pkg::ATTR_DP];
			assign term_pages[gi]  = {1'b0, end_ff[gi]} - {1'b0, start_ff[gi]} + 25'h0000001;
			assign term_hit[gi]    = ttype != mapper_pkg::TYPE_EMPTY && cyc_addr[31:8] >= start_ff[gi]
			                         && cyc_addr[31:8] <= end_ff[gi];
		end
	endgenerate

	// A foreground monitor owns the dual-ported block, so users only get it with the background one.
	mem_block_allocator u_alloc (
		.term_emul   (term_emul),
		.term_dp_req (term_dp_req),
		.term_pages  (term_pages),
		.slot0_size  (ctrl_ff[mapper_pkg::CTRL_SLOT0_LSB +: 2]),
		.slot1_size  (ctrl_ff[mapper_pkg::CTRL_SLOT1_LSB +: 2]),
		.dp_free     (mon_bg),
		.term_block  (term_block),
		.term_fail   (term_fail)
	);

	// Choose the hit term; ranges may overlap, and then the lowest index wins.
	logic [5:0] hit_attr;
	logic [2:0] hit_block;
	logic       any_hit;
	always_comb begin
		hit_attr = 6'h00;
		hit_block = mapper_pkg::BLK_NONE;
		any_hit = 1'b0;
		for (int t = mapper_pkg::NUM_TERMS - 1; t >= 0; t--) begin
			if (term_hit[t]) begin
				hit_attr = attr_ff[t];
				hit_block = term_block[t];
				any_hit = 1'b1;
			end
		end
	end

	// Effective type and attributes; unmapped space falls to the default.
	wire [2:0] hit_type  = hit_attr[mapper_pkg::ATTR_TYPE_LSB +: 3];
	wire       hit_emul  = any_hit && (hit_type == mapper_pkg::TYPE_ERAM || hit_type == mapper_pkg::TYPE_EROM);
	wire       no_block  = hit_emul && hit_block == mapper_pkg::BLK_NONE;
	wire       def_grd   = !any_hit && def_type == mapper_pkg::DEF_GRD;
	wire       def_tci   = !any_hit && (def_type == mapper_pkg::DEF_TRAM_TCI
	                       || def_type == mapper_pkg::DEF_TROM_TCI);
	wire       is_grd    = (any_hit && hit_type == mapper_pkg::TYPE_GRD) || def_grd || no_block;
	wire       is_emul   = hit_emul && !no_block;
	wire       use_lock  = is_emul && hit_attr[mapper_pkg::ATTR_LOCK];
	wire       use_tci   = (any_hit && hit_attr[mapper_pkg::ATTR_TCI]) || def_tci;
	wire       rom_write = is_emul && hit_type == mapper_pkg::TYPE_EROM && cyc_write && rom_brk_en;

	// Cycle sequencing.
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (cyc_start) begin
					if (is_grd || (is_emul && !use_lock)) begin
						nxt_state = ST_INTERN;
					end else if (use_lock) begin
						nxt_state = ST_LOCKED;
					end else begin
						nxt_state = ST_TARGET;
					end
				end
			end
			ST_INTERN: nxt_state = ST_IDLE;
			ST_LOCKED: begin
				// Without a target answer this waits forever; the target must supply one.
				if (xfer_ack_in || xfer_error_ack_in) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_TARGET: begin
				if (xfer_ack_in || xfer_error_ack_in) begin
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	wire cyc_done   = (state_ff == ST_INTERN) || ((state_ff == ST_LOCKED || state_ff == ST_TARGET)
	                  && (xfer_ack_in || xfer_error_ack_in));
	wire start_take = state_ff == ST_IDLE && cyc_start;

	// Steering outputs are latched at address time and held through the cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_ff <= ST_IDLE;
			emul_sel_ff <= 1'b0;
			emul_block_ff <= mapper_pkg::BLK_NONE;
			emul_dual_port_ff <= 1'b0;
			target_sel_ff <= 1'b0;
			cache_inhibit_ff <= 1'b0;
			pend_break_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			if (start_take) begin
				emul_sel_ff <= is_emul;
				emul_block_ff <= is_emul ? hit_block : mapper_pkg::BLK_NONE;
				emul_dual_port_ff <= is_emul && hit_block == mapper_pkg::BLK_DP;
				target_sel_ff <= !is_emul && !is_grd;
				cache_inhibit_ff <= use_tci;
				pend_break_ff <= is_grd || rom_write;
			end else if (cyc_done) begin
				emul_sel_ff <= 1'b0;
				emul_block_ff <= mapper_pkg::BLK_NONE;
				emul_dual_port_ff <= 1'b0;
				target_sel_ff <= 1'b0;
				cache_inhibit_ff <= 1'b0;
				pend_break_ff <= 1'b0;
			end
		end
	end

	// Termination pulses; locked emulation cycles forward the target's own answer.
	wire emul_locked_end = state_ff == ST_LOCKED && (xfer_ack_in || xfer_error_ack_in);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc_ack_ff <= 1'b0;
			cyc_err_ack_ff <= 1'b0;
			monitor_break_ff <= 1'b0;
			guarded_hit_ff <= 1'b0;
		end else begin
			cyc_ack_ff <= state_ff == ST_INTERN || (emul_locked_end && !xfer_error_ack_in);
			cyc_err_ack_ff <= emul_locked_end && xfer_error_ack_in;
			monitor_break_ff <= cyc_done && pend_break_ff;
			guarded_hit_ff <= state_ff == ST_INTERN && pend_break_ff && !emul_sel_ff;
		end
	end

	// Register file; a map clear wins over a term write in the same cycle.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ctrl_ff <= mapper_pkg::CTRL_RESET;
			mon_base_ff <= 32'h00000000;
			mask_ff <= 3'h0;
			for (int t = 0; t < mapper_pkg::NUM_TERMS; t++) begin
				start_ff[t] <= 24'h000000;
				end_ff[t] <= 24'h000000;
				attr_ff[t] <= 6'h00;
			end
		end else begin
			if (wr_ctrl) ctrl_ff <= hwdata[9:0];
			if (wr_base) mon_base_ff <= hwdata;
			if (wr_mask) mask_ff <= hwdata[2:0];
			for (int t = 0; t < mapper_pkg::NUM_TERMS; t++) begin
				if (map_clear) begin
					attr_ff[t] <= 6'h00;
				end else if (wr_term && term_idx == 3'(t)) begin
					if (addr_ff[3:2] == 2'h0) start_ff[t] <= hwdata[31:8];
					if (addr_ff[3:2] == 2'h1) end_ff[t] <= hwdata[31:8];
					if (addr_ff[3:2] == 2'h2) attr_ff[t] <= hwdata[5:0];
				end
			end
		end
	end

	// Sticky events; a new event in the clearing cycle stays set.
	// The ROM-write event is taken at the ending edge, because the select is already gone once the break shows.
	wire [2:0] ev_set = {start_take && no_block, cyc_done && pend_break_ff && emul_sel_ff, guarded_hit_ff};
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_ff <= 3'h0;
			irq_ff <= 1'b0;
		end else begin
			status_ff <= (status_ff & ~(wr_status ? hwdata[2:0] : 3'h0)) | ev_set;
			irq_ff <= |(status_ff & mask_ff);
		end
	end

	// Read mux on the latched address; the live bus address may already belong to the next transfer.
	always_comb begin
		rdata = 32'h00000000;
		if (addr_ff[7] && addr_ff[6:4] != 3'h7) begin
			case (addr_ff[3:2])
				2'h0:    rdata = {start_ff[addr_ff[6:4]], 8'h00};
				2'h1:    rdata = {end_ff[addr_ff[6:4]], 8'hff};
				2'h2:    rdata = {23'h000000, term_block[addr_ff[6:4]], attr_ff[addr_ff[6:4]]};
				default: rdata = 32'h00000000;
			endcase
		end else begin
			case (addr_ff[7:0])
				mapper_pkg::OFS_CTRL:     rdata = {22'h000000, ctrl_ff};
				mapper_pkg::OFS_MON_BASE: rdata = mon_base_ff;
				mapper_pkg::OFS_STATUS:   rdata = {29'h00000000, status_ff};
				mapper_pkg::OFS_MASK:     rdata = {29'h00000000, mask_ff};
				mapper_pkg::OFS_ALLOC:    rdata = {25'h0000000, term_fail};
				default:                  rdata = 32'h00000000;
			endcase
		end
	end

	// One wait state on reads keeps a read behind a write from returning stale data.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			rd_pend_ff <= 1'b0;
			addr_ff <= 8'h00;
			hrdata_ff <= 32'h00000000;
			hreadyout_ff <= 1'b1;
		end else begin
			wr_pend_ff <= addr_phase && hwrite;
			rd_pend_ff <= addr_phase && !hwrite;
			if (addr_phase) addr_ff <= haddr[7:0];
			hreadyout_ff <= !(addr_phase && !hwrite);
			if (rd_pend_ff) hrdata_ff <= rdata;
		end
	end

	assign hrdata         = hrdata_ff;
	assign hreadyout      = hreadyout_ff;
	assign hresp          = 1'b0;
	assign irq            = irq_ff;
	assign emul_sel       = emul_sel_ff;
	assign emul_block     = emul_block_ff;
	assign emul_dual_port = emul_dual_port_ff;
	assign target_sel     = target_sel_ff;
	assign cache_inhibit  = cache_inhibit_ff;
	assign cyc_ack        = cyc_ack_ff;
	assign cyc_err_ack    = cyc_err_ack_ff;
	assign monitor_break  = monitor_break_ff;
	assign guarded_hit    = guarded_hit_ff;
endmodule

// >>> logic/mapper_pkg.sv
package mapper_pkg;
	localparam int          NUM_TERMS      = 7;
	localparam int          PAGE_BITS      = 24;    // Address bits above the 256-byte page offset.
	// Register byte offsets.
	localparam logic [7:0]  OFS_CTRL       = 8'h00;
	localparam logic [7:0]  OFS_MON_BASE   = 8'h04;
	localparam logic [7:0]  OFS_CMD        = 8'h08;
	localparam logic [7:0]  OFS_STATUS     = 8'h0c;
	localparam logic [7:0]  OFS_MASK       = 8'h10;
	localparam logic [7:0]  OFS_ALLOC      = 8'h14;
	localparam logic [7:0]  OFS_TERM_BASE  = 8'h80;  // Term n at 0x80 + 16*n: start, end, attr.
	// Control register fields.
	localparam int          CTRL_MON_BG    = 0;
	localparam int          CTRL_ROM_BRK   = 1;
	localparam int          CTRL_DEF_LSB   = 2;     // Three bits.
	localparam int          CTRL_SLOT0_LSB = 6;     // Two bits.
	localparam int          CTRL_SLOT1_LSB = 8;     // Two bits.
	localparam logic [9:0]  CTRL_RESET     = 10'h000;
	localparam int          CMD_MAP_RESET  = 0;
	// Status and mask bits.
	localparam int          ST_GUARDED     = 0;
	localparam int          ST_ROM_WRITE   = 1;
	localparam int          ST_NO_BLOCK    = 2;
	localparam int          ST_BITS        = 3;
	// Term attribute fields.
	localparam int          ATTR_TYPE_LSB  = 0;     // Three bits.
	localparam int          ATTR_DP        = 3;
	localparam int          ATTR_LOCK      = 4;
	localparam int          ATTR_TCI       = 5;
	localparam logic [2:0]  TYPE_EMPTY     = 3'h0;
	localparam logic [2:0]  TYPE_ERAM      = 3'h1;
	localparam logic [2:0]  TYPE_EROM      = 3'h2;
	localparam logic [2:0]  TYPE_TRAM      = 3'h3;
	localparam logic [2:0]  TYPE_TROM      = 3'h4;
	localparam logic [2:0]  TYPE_GRD       = 3'h5;
	// Default type codes for unmapped space.
	localparam logic [2:0]  DEF_TRAM       = 3'h0;
	localparam logic [2:0]  DEF_TRAM_TCI   = 3'h1;
	localparam logic [2:0]  DEF_TROM       = 3'h2;
	localparam logic [2:0]  DEF_TROM_TCI   = 3'h3;
	localparam logic [2:0]  DEF_GRD        = 3'h4;
	// Slot fitting codes and sizes in 256-byte pages.
	localparam logic [1:0]  SLOT_EMPTY     = 2'h0;
	localparam logic [1:0]  SLOT_256K      = 2'h1;
	localparam logic [1:0]  SLOT_1M        = 2'h2;
	localparam logic [1:0]  SLOT_4M        = 2'h3;
	localparam logic [24:0] PAGES_256K     = 25'h0000400;
	localparam logic [24:0] PAGES_1M       = 25'h0001000;
	localparam logic [24:0] PAGES_4M       = 25'h0004000;
	localparam logic [24:0] PAGES_DP       = 25'h0000010;  // The 4-Kbyte dual-ported block.
	// Block indices.
	localparam logic [2:0]  BLK_DP         = 3'h6;
	localparam logic [2:0]  BLK_NONE       = 3'h7;
endpackage

// >>> logic/mem_block_allocator.sv
`timescale 1ns/100ps
// Assigns physical probe blocks to emulation terms in term order.
module mem_block_allocator (
	input  wire logic [6:0]  term_emul,     // Term is an emulation memory term.
	input  wire logic [6:0]  term_dp_req,   // Term asks for the dual-ported block.
	input  wire logic [24:0] term_pages [7], // Term size in 256-byte pages.
	input  wire logic [1:0]  slot0_size,    // Slot 0 fitting code.
	input  wire logic [1:0]  slot1_size,    // Slot 1 fitting code.
	input  wire logic        dp_free,       // Dual-ported block open for user terms.
	output logic      [2:0]  term_block [7], // Block index per term, none when unplaced.
	output logic      [6:0]  term_fail      // Emulation term found no block.
);
	logic [24:0] blk0_pages;
	logic [24:0] blk1_pages;

	// Slot size in pages for a fitting code.
	function automatic logic [24:0] slot_pages(input logic [1:0] code);
		case (code)
			mapper_pkg::SLOT_256K: slot_pages = mapper_pkg::PAGES_256K;
			mapper_pkg::SLOT_1M:   slot_pages = mapper_pkg::PAGES_1M;
			mapper_pkg::SLOT_4M:   slot_pages = mapper_pkg::PAGES_4M;
			default:               slot_pages = 25'h0000000;
		endcase
	endfunction

	// Slot 0 splits in quarters, slot 1 in halves; an empty slot yields nothing.
	assign blk0_pages = slot_pages(slot0_size) >> 2;
	assign blk1_pages = slot_pages(slot1_size) >> 1;

	// Greedy walk: a block once taken is gone, even if the term uses a sliver of it.
	always_comb begin
		logic [6:0]  used;
		logic [2:0]  best;
		logic [24:0] best_sz;
		logic [24:0] sz;
		used = 7'h00;
		best = mapper_pkg::BLK_NONE;
		best_sz = 25'h1ffffff;
		sz = 25'h0000000;
		term_fail = 7'h00;
		for (int t = 0; t < mapper_pkg::NUM_TERMS; t++) begin
			term_block[t] = mapper_pkg::BLK_NONE;
			best = mapper_pkg::BLK_NONE;
			best_sz = 25'h1ffffff;
			if (term_emul[t]) begin
				if (dp_free && !used[6] && term_pages[t] <= mapper_pkg::PAGES_DP) begin
					term_block[t] = mapper_pkg::BLK_DP;
					used[6] = 1'b1;
				end else if (!term_dp_req[t]) begin
					for (int b = 0; b < 6; b++) begin
						sz = (b < 4) ? blk0_pages : blk1_pages;
						if (!used[b] && sz != 25'h0000000 && sz >= term_pages[t] && sz < best_sz) begin
							best = 3'(b);
							best_sz = sz;
						end
					end
					term_block[t] = best;
					if (best != mapper_pkg::BLK_NONE) begin
						used[best] = 1'b1;
					end
				end
				term_fail[t] = (term_block[t] == mapper_pkg::BLK_NONE);
			end
		end
	end
endmodule

// >>> test/mapper_checker_assertions.sv
`timescale 1ns/100ps
// Watches the mapper's cycle ports; a lost termination or a stray break fails here.
module mapper_checker (
	input wire logic xfer_ack_in,       // Target ack.
	input wire logic hclk,              // Clock.
	input wire logic hresetn,           // Reset, active low.
	input wire logic cyc_start,         // Cycle start.
	input wire logic xfer_error_ack_in, // Target error ack.
	input wire logic emul_sel,          // Emulation select.
	input wire logic target_sel,        // Target select.
	input wire logic cyc_ack,           // Internal ack.
	input wire logic cyc_err_ack,       // Error ack.
	input wire logic monitor_break,     // Break pulse.
	input wire logic guarded_hit        // Guarded pulse.
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	// A guarded cycle shows no select and ends one cycle later with a break.
	sequence s_guard_end;
		##1 (cyc_ack && monitor_break);
	endsequence
	sequence s_one_shot;
		##1 !guarded_hit;
	endsequence

	// Only a start seen while idle is decoded; a busy start is refused by design.
	a_start_decode: assert property (cyc_start && !$past(cyc_start) && !emul_sel && !target_sel && !cyc_ack
		&& !cyc_err_ack |=> (emul_sel || target_sel) or s_guard_end) else $error("start not decoded");
	a_emul_term: assert property ($fell(emul_sel) |-> cyc_ack || cyc_err_ack) else $error("cycle not ended");
	a_err_cause: assert property (cyc_err_ack |-> $past(xfer_error_ack_in)) else $error("stray error ack");
	a_target_end: assert property (target_sel && xfer_ack_in |=> !target_sel) else $error("target cycle hung");
	a_target_quiet: assert property (target_sel |-> !cyc_ack && !cyc_err_ack) else $error("ack on target");
	a_guard_pulse: assert property (guarded_hit |-> monitor_break && cyc_ack ##0 s_one_shot)
		else $error("guarded pulse wrong");
	a_break_with_ack: assert property (monitor_break |-> (cyc_ack || cyc_err_ack) ##1 !monitor_break)
		else $error("break not at end");
	a_ack_single: assert property (cyc_ack |-> !emul_sel ##1 !cyc_ack) else $error("ack too long");
	a_sel_exclusive: assert property (!(emul_sel && target_sel)) else $error("both selects");
endmodule

bind emulation_memory_mapper mapper_checker u_chk (.hclk, .hresetn, .cyc_start, .xfer_ack_in, .xfer_error_ack_in,
	.emul_sel, .target_sel, .cyc_ack, .cyc_err_ack, .monitor_break, .guarded_hit);

// >>> test/target_model.sv
`timescale 1ns/100ps
// Target memory: answers once a select has stayed high for a chosen number of cycles.
module target_model (
	input  wire logic       hclk,              // Clock.
	input  wire logic       hresetn,           // Reset, active low.
	input  wire logic       emul_sel,          // Emulation cycle.
	input  wire logic       target_sel,        // Target cycle.
	input  wire logic       err_mode,          // Answer with error ack.
	input  wire logic [1:0] delay,             // Cycles before the answer.
	output logic            xfer_ack_in,       // Transfer ack.
	output logic            xfer_error_ack_in  // Error ack.
);
	logic [2:0] wait_ff;
	wire        sel = emul_sel | target_sel;
	wire        hit = sel && wait_ff == {1'b0, delay};

	// Any select still high after delay cycles is answered, so a locked cycle can never hang.
	assign xfer_ack_in       = hit && !err_mode;
	assign xfer_error_ack_in = hit && err_mode;

	// Counts the cycles a select has been high.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			wait_ff <= 3'h0;
		else
			wait_ff <= sel ? wait_ff + 3'h1 : 3'h0;
	end
endmodule

// >>> test/emulation_memory_mapper_tb_top.sv
`timescale 1ns/100ps
// Self-checking bench: register setup over the bus, then directed and random processor cycles.
module emulation_memory_mapper_tb_top;
	logic        hclk, hresetn, hsel, hwrite, cyc_start, cyc_write, err_mode;
	logic [31:0] haddr, hwdata, cyc_addr, rd, rs, a;
	logic [1:0]  htrans, delay;
	logic [2:0]  blk, dflt;
	wire  [31:0] hrdata;
	wire  [2:0]  emul_block;
	wire         hreadyout, hresp, irq, emul_sel, emul_dual_port, target_sel, cache_inhibit;
	wire         cyc_ack, cyc_err_ack, monitor_break, guarded_hit, xfer_ack_in, xfer_error_ack_in;
	int          error_cnt, tests_run, i, k;
	logic        mapped, dpp;
	// Non-overlapping terms on 256-byte pages; attr is {tci, lock, dp, type}.
	logic [31:0] ts [7] = '{32'h0, 32'h50000, 32'h60000, 32'h70000, 32'h80000, 32'h90000, 32'ha0000};
	logic [31:0] te [7] = '{32'h7fff, 32'h500ff, 32'h6ffff, 32'h7ffff, 32'h800ff, 32'h900ff, 32'hbffff};
	logic [5:0]  at [7] = '{6'h01, 6'h01, 6'h11, 6'h02, 6'h05, 6'h23, 6'h21};

	emulation_memory_mapper u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
		.hready(hreadyout), .hrdata, .hreadyout, .hresp, .irq, .cyc_start, .cyc_addr, .cyc_write, .xfer_ack_in,
		.xfer_error_ack_in, .emul_sel, .emul_block, .emul_dual_port, .target_sel, .cache_inhibit, .cyc_ack,
		.cyc_err_ack, .monitor_break, .guarded_hit);
	target_model u_tgt (.hclk, .hresetn, .emul_sel, .target_sel, .err_mode, .delay, .xfer_ack_in,
		.xfer_error_ack_in);

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	function automatic logic [31:0] rnd();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction

	// Expected {emul, target, tci, break, guarded, locked} for one processor cycle.
	function automatic logic [5:0] expect_of(input logic [31:0] ad, input logic w);
		logic [2:0] t;
		logic       tci, lk, em;
		t = dflt == mapper_pkg::DEF_GRD ? mapper_pkg::TYPE_GRD
			: (dflt[1] ? mapper_pkg::TYPE_TROM : mapper_pkg::TYPE_TRAM);
		tci = dflt[0] && !dflt[2];
		lk = 1'b0;
		for (int j = 0; j < 7; j++)
			if (mapped && ad >= ts[j] && ad <= te[j]) begin
				t = at[j][2:0];
				tci = at[j][5];
				lk = at[j][4];
			end
		em = t == mapper_pkg::TYPE_ERAM || t == mapper_pkg::TYPE_EROM;
		return {em, t == mapper_pkg::TYPE_TRAM || t == mapper_pkg::TYPE_TROM, tci,
			t == mapper_pkg::TYPE_GRD || (t == mapper_pkg::TYPE_EROM && w), t == mapper_pkg::TYPE_GRD, em && lk};
	endfunction

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			error_cnt++;
			$display("unexpected %0t got %h want %h", $time, got, exp);
		end
	endtask

	// One single transfer; entered just after a rising edge, read data kept in rd.
	task automatic bus(input logic w, input logic [31:0] ad, input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= ad;
		hwrite <= w;
		do @(negedge hclk); while (!hreadyout);
		@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(negedge hclk); while (!hreadyout);
		rd = hrdata;
		chk(hresp, 1'b0);
		@(posedge hclk);
	endtask

	// Background monitor keeps the dual-ported block free; both slots hold 256K parts.
	task automatic ctrl(input logic [2:0] d);
		dflt = d;
		bus(1'b1, 32'h0, {22'h0, 2'h1, 2'h1, 1'b0, d, 2'h3});
	endtask

	task automatic prog();
		for (int j = 0; j < 7; j++) begin
			bus(1'b1, 32'h80 + 32'(j * 16), ts[j]);
			bus(1'b1, 32'h84 + 32'(j * 16), te[j]);
			bus(1'b1, 32'h88 + 32'(j * 16), {26'h0, at[j]});
		end
		mapped = 1'b1;
	endtask

	// Runs one processor cycle with a random target delay and checks routing and length.
	task automatic run_cyc(input logic [31:0] ad, input logic w);
		logic [5:0] e, g;
		logic [1:0] d;
		int         n;
		e = expect_of(ad, w);
		g = '0;
		n = 0;
		d = 2'(rnd());
		cyc_start <= 1'b1;
		cyc_addr <= ad;
		cyc_write <= w;
		delay <= d;
		err_mode <= e[5] & rs[7];
		@(posedge hclk);
		cyc_start <= 1'b0;
		do begin
			@(negedge hclk);
			n++;
			g |= {emul_sel, target_sel, cache_inhibit, monitor_break, guarded_hit, cyc_err_ack};
			if (emul_sel) begin
				blk = emul_block;
				dpp = emul_dual_port;
			end
		end while (!cyc_ack && !cyc_err_ack && !(g[4] && !target_sel) && n < 20);
		@(posedge hclk);
		chk(g[5:1], e[5:1]);
		chk(g[0], e[0] & err_mode);
		chk(n, (e[0] || e[4]) ? 32'(d) + 32'h2 : 32'h2);
	endtask

	task automatic summarize();
		if (error_cnt == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// The whole sequence needs well under a thousand cycles; this limit only cuts a hang.
	initial begin
		repeat (20000) @(posedge hclk);
		error_cnt++;
		summarize();
	end

	initial begin
		{hresetn, hsel, haddr, htrans, hwrite, hwdata, cyc_start, cyc_addr, cyc_write, delay, err_mode} = '0;
		{error_cnt, tests_run, mapped, dpp, dflt, blk} = '0;
		rs = 32'h99bab929;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		bus(1'b1, 32'h10, 32'h1);
		ctrl(mapper_pkg::DEF_TRAM);
		prog();
		bus(1'b0, 32'h14, 32'h0);
		chk(rd[6:0], 7'h00);
		run_cyc(32'h50010, 1'b0);
		chk(blk, mapper_pkg::BLK_DP);
		chk(dpp, 1'b1);
		run_cyc(32'h100, 1'b1);
		chk(blk[2], 1'b0);
		chk(dpp, 1'b0);
		run_cyc(32'ha0000, 1'b0);
		chk(blk[2:1], 2'h2);
		for (i = 0; i < 5; i++) begin
			ctrl(3'(i));
			run_cyc(32'h8000, rs[3]);
		end
		repeat (2) @(negedge hclk);
		chk(irq, 1'b1);
		@(posedge hclk);
		bus(1'b0, 32'hc, 32'h0);
		chk(rd[2:0], 3'h1);
		bus(1'b1, 32'hc, 32'h7);
		repeat (2) @(negedge hclk);
		chk(irq, 1'b0);
		@(posedge hclk);
		repeat (60) begin
			i = int'(rnd() % 8);
			a = (i == 7) ? 32'h8000 + (rnd() & 32'hff00) : ts[i] + rnd() % (te[i] - ts[i] + 32'h1);
			run_cyc(a, rs[9]);
		end
		for (k = 0; k < 2; k++) begin
			prog();
			bus(1'b1, k ? 32'h4 : 32'h8, 32'h101);
			mapped = 1'b0;
			run_cyc(32'h90000, 1'b0);
			bus(1'b0, 32'hd8, 32'h0);
			chk(rd[2:0], mapper_pkg::TYPE_EMPTY);
		end
		summarize();
	end
endmodule
